// ==== include/dim_pkg.sv ====
/*
 * constants, types and helpers shared by the two-channel interpolating
 * delta-sigma output front end and its coefficient memory.
 * assumes one 50 MHz clock with an asynchronous active-high reset.
 */
package dim_pkg;

    // ****************************************
    // widths and rates
    // ****************************************
    localparam int SMP_W     = 16;
    localparam int COEF_W    = 16;
    localparam int COEF_FRAC = 14;
    localparam int ACC_W     = 34;
    localparam int INT_W     = 24;
    localparam int ADDR_W    = 5;
    localparam int TAPS      = 4;
    localparam int CNT_W     = 7;
    localparam int PH_W      = 3;
    localparam int ZCNT_W    = 13;
    localparam int OS_DIV    = 16;
    localparam int INTERP    = 8;
    localparam int PER_CLKS  = OS_DIV * INTERP;

    // ****************************************
    // sequencing points inside one eight-times period
    // ****************************************
    localparam logic [CNT_W-1:0]  CNT_LAST    = 7'h7F;
    localparam logic [CNT_W-1:0]  CNT_MAC_BEG = 7'h01;
    localparam logic [CNT_W-1:0]  CNT_MAC_END = 7'h04;
    localparam logic [CNT_W-1:0]  CNT_LOAD    = 7'h05;
    localparam logic [3:0]        TICK_SUB    = 4'hF;

    // ****************************************
    // mute detector and modulator levels
    // ****************************************
    localparam logic [ZCNT_W-1:0]       MUTE_RUN    = 13'h1000;
    localparam logic [ZCNT_W-1:0]       MUTE_RUN_M1 = 13'h0FFF;
    localparam logic signed [INT_W-1:0] FB_MAG      = 24'sh008000;
    localparam logic signed [SMP_W-1:0] SMP_MAX     = 16'sh7FFF;
    localparam logic signed [SMP_W-1:0] SMP_MIN     = 16'sh8000;

    typedef enum logic {
        DIM_RUN  = 1'b0,
        DIM_MUTE = 1'b1
    } dim_mode_t;

    // clip a wide filter sum back to the sample width
    function automatic logic signed [SMP_W-1:0] dim_sat(input logic signed [ACC_W-1:0] v);
        logic signed [ACC_W-1:0] s;
        s = v >>> COEF_FRAC;
        if (s > ACC_W'(SMP_MAX)) begin
            dim_sat = SMP_MAX;
        end else if (s < ACC_W'(SMP_MIN)) begin
            dim_sat = SMP_MIN;
        end else begin
            dim_sat = s[SMP_W-1:0];
        end
    endfunction

endpackage

// ==== hdl/dim_coef_rom.sv ====
/*
 * coefficient memory of the 32-tap symmetric interpolation lowpass.
 * assumes the caller presents an address one cycle before it needs the word.
 */
`timescale 1ns/100ps
module dim_coef_rom (
    // clock and reset
    input  wire logic                                  clk_sys,
    input  wire logic                                  rst,
    // read port
    input  wire logic [dim_pkg::ADDR_W-1:0]            addr,
    output logic signed [dim_pkg::COEF_W-1:0]          coef
);
    import dim_pkg::*;

    // ****************************************
    // half table, mirrored: keeps the phase linear
    // ****************************************
    function automatic logic signed [COEF_W-1:0] half_tab(input logic [3:0] i);
        case (i)
            4'h0:    half_tab = -16'sh0001;
            4'h1:    half_tab = -16'sh0022;
            4'h2:    half_tab = -16'sh0098;
            4'h3:    half_tab = -16'sh0174;
            4'h4:    half_tab = -16'sh028B;
            4'h5:    half_tab = -16'sh0369;
            4'h6:    half_tab = -16'sh0361;
            4'h7:    half_tab = -16'sh01B0;
            4'h8:    half_tab = 16'sh0253;
            4'h9:    half_tab = 16'sh08FD;
            4'hA:    half_tab = 16'sh1221;
            4'hB:    half_tab = 16'sh1D07;
            4'hC:    half_tab = 16'sh287E;
            4'hD:    half_tab = 16'sh3301;
            4'hE:    half_tab = 16'sh3B0E;
            default: half_tab = 16'sh3F70;
        endcase
    endfunction

    logic [3:0] idx;
    assign idx = addr[4] ? ~addr[3:0] : addr[3:0];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            coef <= 16'sh0000;
        end else begin
            coef <= half_tab(idx);
        end
    end
endmodule

// ==== hdl/dim_front.sv ====
/*
 * two-channel interpolate-by-eight lowpass, zero-order hold, second-order
 * delta-sigma modulator at 64 times the base rate and zero-run mute.
 * assumes the upstream source sits on clk_sys and answers smp_req.
 */
// Summary of operation
// RQ1: raise each channel to eight-times rate first
// RQ2: linear-phase lowpass, output at eight-times rate
// RQ3: hold each filtered value one eight-times period
// RQ4: modulator at 64-times rate gives one bit
// RQ5: loop pushes quantisation noise above signal band
// RQ6: modulator bit goes straight to converter pin
// RQ7: mute after 4096 zero pairs; nonzero restarts
// RQ8: muted outputs clamp to ground while zeros
// RQ9: any nonzero sample ends mute at once
// RQ10: source gives paired 16-bit samples each period
// RQ11: reset clears filter, integrators, counter, unmuted
`timescale 1ns/100ps
module dim_front (
    // clock and reset
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    // upstream samples
    input  wire logic                              smp_valid,
    input  wire logic signed [dim_pkg::SMP_W-1:0]  smp_l,
    input  wire logic signed [dim_pkg::SMP_W-1:0]  smp_r,
    output logic                                   smp_req,
    // converter side
    output logic                                   dac_bit_l,
    output logic                                   dac_bit_r,
    output logic                                   dac_clamp
);
    import dim_pkg::*;

    // ****************************************
    // rate sequencer
    // ****************************************
    logic [CNT_W-1:0]   cnt_q;
    logic [PH_W-1:0]    ph_q;
    logic               base_start;
    logic               tick;
    logic               mac_en;
    logic               mac_first;
    logic               load;
    logic [1:0]         tap;
    logic [ADDR_W-1:0]  rom_addr;
    logic signed [COEF_W-1:0] coef_q;

    // base period = 8 phases of 128 clocks; 64-times tick every 16 clocks
    assign base_start = (cnt_q == '0) && (ph_q == '0);
    assign tick       = (cnt_q[3:0] == TICK_SUB);
    assign mac_en     = (cnt_q != '0) && (cnt_q <= CNT_MAC_END);
    assign mac_first  = (cnt_q == CNT_MAC_BEG);
    assign load       = (cnt_q == CNT_LOAD);
    assign tap        = cnt_q[1:0] - 2'h1;
    assign rom_addr   = {cnt_q[1:0], ph_q};
    assign smp_req    = base_start;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            ph_q  <= '0;
        end else begin
            cnt_q <= cnt_q + 7'h01;
            if (cnt_q == CNT_LAST) begin
                ph_q <= ph_q + 3'h1;
            end
        end
    end

    dim_coef_rom u_rom (
        .clk_sys (clk_sys),
        .rst     (rst),
        .addr    (rom_addr),
        .coef    (coef_q)
    );

    // ****************************************
    // mute detector
    // ****************************************
    dim_mode_t          mode_q;
    dim_mode_t          mode_d;
    logic [ZCNT_W-1:0]  zcnt_q;
    logic [ZCNT_W-1:0]  zcnt_d;
    logic               both_zero;
    logic               mute_q;

    assign both_zero = (smp_l == '0) && (smp_r == '0);
    assign mute_q    = (mode_q == DIM_MUTE);
    assign dac_clamp = mute_q;  // see RQ8

    // counter saturates so a long silence cannot wrap back to unmuted
    always_comb begin
        zcnt_d = zcnt_q;
        if (smp_valid) begin
            if (!both_zero) begin
                zcnt_d = '0;  // see RQ7
            end else if (zcnt_q != MUTE_RUN) begin
                zcnt_d = zcnt_q + 13'h0001;
            end
        end
    end

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            DIM_RUN: begin
                if (smp_valid && both_zero && (zcnt_q == MUTE_RUN_M1)) begin
                    mode_d = DIM_MUTE;  // see RQ7
                end
            end
            DIM_MUTE: begin
                if (smp_valid && !both_zero) begin
                    mode_d = DIM_RUN;  // see RQ9
                end
            end
            default: mode_d = DIM_RUN;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_q <= DIM_RUN;  // see RQ11
            zcnt_q <= '0;
        end else begin
            mode_q <= mode_d;
            zcnt_q <= zcnt_d;
        end
    end

    // ****************************************
    // per-channel datapath
    // ****************************************
    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic signed [SMP_W-1:0]  smp_in;
        logic signed [SMP_W-1:0]  pend_q;
        logic signed [SMP_W-1:0]  hist_q [TAPS];
        logic signed [ACC_W-1:0]  acc_q;
        logic signed [ACC_W-1:0]  prod;
        logic signed [SMP_W-1:0]  hold_q;
        logic signed [INT_W-1:0]  int1_q;
        logic signed [INT_W-1:0]  int2_q;
        logic signed [INT_W-1:0]  int1_d;
        logic signed [INT_W-1:0]  int2_d;
        logic signed [INT_W-1:0]  x_ext;
        logic signed [INT_W-1:0]  fb;
        logic                     bit_q;
        logic                     out_q;

        assign smp_in = (c == 0) ? smp_l : smp_r;
        assign prod   = ACC_W'(hist_q[tap] * coef_q);
        // half scale input keeps the second-order loop out of overload
        assign x_ext  = {{(INT_W-SMP_W+1){hold_q[SMP_W-1]}}, hold_q[SMP_W-1:1]};
        assign fb     = bit_q ? FB_MAG : -FB_MAG;
        assign int1_d = int1_q + x_ext - fb;  // see RQ5
        // second stage takes the fresh first sum: keeps the loop poles inside the unit circle
        assign int2_d = int2_q + int1_d - fb;  // see RQ5

        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                pend_q <= '0;
                hist_q <= '{default: '0};  // see RQ11
            end else begin
                if (smp_valid) begin
                    pend_q <= smp_in;
                end
                // polyphase form: same as zero-stuffing by eight
                if (base_start) begin
                    hist_q[0] <= smp_valid ? smp_in : pend_q;  // see RQ1
                    hist_q[1] <= hist_q[0];
                    hist_q[2] <= hist_q[1];
                    hist_q[3] <= hist_q[2];
                end
            end
        end

        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                acc_q  <= '0;
                hold_q <= '0;
            end else begin
                if (mac_en) begin
                    acc_q <= (mac_first ? '0 : acc_q) + prod;  // see RQ2
                end
                if (load) begin
                    hold_q <= dim_sat(acc_q);  // see RQ3
                end
            end
        end

        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                int1_q <= '0;
                int2_q <= '0;
                bit_q  <= 1'b0;
                out_q  <= 1'b0;
            end else begin
                if (tick) begin
                    int1_q <= int1_d;  // see RQ4
                    int2_q <= int2_d;
                    bit_q  <= !int2_d[INT_W-1];
                    out_q  <= !int2_d[INT_W-1];  // see RQ6
                end
                if (mute_q) begin
                    out_q <= 1'b0;  // see RQ8
                end
            end
        end
    end

    assign dac_bit_l = g_ch[0].out_q;
    assign dac_bit_r = g_ch[1].out_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_zero_last;
        smp_valid && both_zero && (zcnt_q == MUTE_RUN_M1) && !mute_q;
    endsequence

    sequence s_nonzero;
        smp_valid && !both_zero;
    endsequence

    a_upsample_base: assert property ($changed(g_ch[0].hist_q[0]) |-> $past(base_start))  // see RQ1
        else $error("sample history moved off the base boundary");
    a_filter_load: assert property (load |=> g_ch[0].hold_q == dim_sat($past(g_ch[0].acc_q)))  // see RQ2
        else $error("filter result not loaded at load step");
    a_hold_stable: assert property ((cnt_q != CNT_LOAD) |=> $stable(g_ch[1].hold_q))  // see RQ3
        else $error("held value changed inside its period");
    a_mod_tick: assert property (!tick |=> $stable(g_ch[0].bit_q) && $stable(g_ch[0].int2_q))  // see RQ4
        else $error("modulator stepped off its tick");
    a_noise_loop: assert property (tick |=> g_ch[1].bit_q == !g_ch[1].int2_q[INT_W-1])  // see RQ5
        else $error("quantiser does not follow loop sign");
    a_loop_bound: assert property ((g_ch[0].int2_q < 24'sh100000) && (g_ch[0].int2_q > -24'sh100000) &&  // see RQ5
                                   (g_ch[1].int2_q < 24'sh100000) && (g_ch[1].int2_q > -24'sh100000))
        else $error("second integrator left its working range");
    a_dac_direct: assert property (tick && !mute_q |=> dac_bit_l == g_ch[0].bit_q)  // see RQ6
        else $error("converter bit differs from modulator bit");
    a_mute_entry: assert property (s_zero_last |=> mute_q ##1 mute_q || $past(smp_valid))  // see RQ7
        else $error("mute not entered after zero run");
    a_mute_cause: assert property ($rose(mute_q) |-> $past(zcnt_q) == MUTE_RUN_M1)  // see RQ7
        else $error("mute entered before zero run complete");
    a_mute_clamp: assert property (mute_q |=> !dac_bit_l && !dac_bit_r)  // see RQ8
        else $error("outputs not grounded while muted");
    a_mute_exit: assert property (s_nonzero |=> !mute_q && zcnt_q == '0)  // see RQ9
        else $error("nonzero sample did not end mute");
    a_zcnt_bound: assert property (zcnt_q <= MUTE_RUN)  // see RQ11
        else $error("zero-run counter passed its ceiling");
endmodule

// ==== tb/dim_src_model.sv ====
/*
 * upstream sample source for the interpolating front end.
 * assumes it shares clk_sys and rst with the front end; the bench steers it.
 */
`timescale 1ns/100ps
module dim_src_model (
    // clock and reset
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    // steering from the bench
    input  wire logic                              hold_on,
    input  wire logic signed [dim_pkg::SMP_W-1:0]  want_l,
    input  wire logic signed [dim_pkg::SMP_W-1:0]  want_r,
    // sample port
    input  wire logic                              smp_req,
    output logic                                   smp_valid,
    output logic signed [dim_pkg::SMP_W-1:0]       smp_l,
    output logic signed [dim_pkg::SMP_W-1:0]       smp_r
);
    import dim_pkg::*;

    // ****************************************
    // one paired sample per request, or a level run
    // ****************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            smp_valid <= 1'b0;
            smp_l     <= 16'h0000;
            smp_r     <= 16'h0000;
        end else if (hold_on || smp_req) begin
            // both channels always leave together, 16 bits each
            smp_valid <= 1'b1;
            smp_l     <= want_l;
            smp_r     <= want_r;
        end else begin
            // idle lines toggle so a stale sample can never look valid
            smp_valid <= 1'b0;
            smp_l     <= ~smp_l;
            smp_r     <= ~smp_r;
        end
    end
endmodule

// ==== tb/tb.sv ====
/*
 * self-checking bench of the interpolating delta-sigma front end.
 * assumes dim_pkg, the front end and the source model are compiled first.
 */
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin \
    comparisons++; \
    if ((got) !== (ex)) begin \
        failures++; \
        $display("unexpected %s expected %0h seen %0h", nm, ex, got); \
    end \
end
module tb;
    import dim_pkg::*;

    // ****************************************
    // signals
    // ****************************************
    logic                    clk_sys     = 1'b0;
    logic                    rst         = 1'b1;
    logic                    hold_on     = 1'b0;
    logic signed [SMP_W-1:0] want_l      = 16'h0000;
    logic signed [SMP_W-1:0] want_r      = 16'h0000;
    logic                    smp_valid;
    logic                    smp_req;
    logic signed [SMP_W-1:0] smp_l;
    logic signed [SMP_W-1:0] smp_r;
    logic                    dac_bit_l;
    logic                    dac_bit_r;
    logic                    dac_clamp;
    int                      failures    = 0;
    int                      comparisons = 0;
    int                      zrun        = 0;

    always #10 clk_sys = ~clk_sys;

    dim_front i_dim_front (.clk_sys(clk_sys), .rst(rst), .smp_valid(smp_valid), .smp_l(smp_l),
        .smp_r(smp_r), .smp_req(smp_req), .dac_bit_l(dac_bit_l), .dac_bit_r(dac_bit_r), .dac_clamp(dac_clamp));
    dim_src_model i_dim_src_model (.clk_sys(clk_sys), .rst(rst), .hold_on(hold_on), .want_l(want_l),
        .want_r(want_r), .smp_req(smp_req), .smp_valid(smp_valid), .smp_l(smp_l), .smp_r(smp_r));

    // run of all-zero pairs taken so far; any nonzero pair restarts it
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            zrun <= 0;
        end else if (smp_valid === 1'b1) begin
            zrun <= (smp_l === 16'h0000 && smp_r === 16'h0000) ? zrun + 1 : 0;
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic end_sim();
        if (failures == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wait_req();
        int n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (smp_req !== 1'b1 && n < 1100);
        `CHK("req_seen", 1'b1, smp_req)
    endtask

    task automatic wait_zrun(input int k);
        int n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (zrun != k && n < 5000);
        `CHK("zrun_seen", k, zrun)
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        int n = 0;
        rst = 1'b1;
        repeat (6) @(negedge clk_sys);
        `CHK("req_rst", 1'b1, smp_req)
        `CHK("bits_rst", 2'b00, {dac_bit_l, dac_bit_r})
        `CHK("clamp_rst", 1'b0, dac_clamp)
        rst = 1'b0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (smp_req !== 1'b1 && n < 2000);
        `CHK("req_gap", 1024, n)
    endtask

    // dc input: ones density of 511 ticks is 256 + v/256 for gain one
    task automatic t_dc(input logic signed [SMP_W-1:0] l, input logic signed [SMP_W-1:0] r);
        int   nl  = 0;
        int   nr  = 0;
        int   bad = 0;
        int   el  = 256 + int'(l) / 256;
        int   er  = 256 + int'(r) / 256;
        logic pl;
        logic pr;
        want_l = l;
        want_r = r;
        repeat (5 * 1024) @(negedge clk_sys);
        wait_req();
        pl = dac_bit_l;
        pr = dac_bit_r;
        for (int i = 1; i < 8192; i++) begin
            @(negedge clk_sys);
            if ((dac_bit_l !== pl || dac_bit_r !== pr) && i % 16 != 0) bad++;
            if (i % 16 == 0) begin
                nl += int'(dac_bit_l === 1'b1);
                nr += int'(dac_bit_r === 1'b1);
            end
            pl = dac_bit_l;
            pr = dac_bit_r;
        end
        `CHK("tick_align", 0, bad)
        `CHK("density_l", 1'b1, 1'(nl > el - 9 && nl < el + 9))
        `CHK("density_r", 1'b1, 1'(nr > er - 9 && nr < er + 9))
    endtask

    task automatic t_mute();
        int bad  = 0;
        int ones = 0;
        wait_req();
        repeat (3) @(negedge clk_sys);
        want_l  = 16'h0000;
        want_r  = 16'h0000;
        hold_on = 1'b1;
        wait_zrun(3000);
        // a lone nonzero right channel must restart the count
        want_r = 16'h8000;
        @(negedge clk_sys);
        want_r = 16'h0000;
        wait_zrun(4095);
        `CHK("clamp_4095", 1'b0, dac_clamp)
        @(negedge clk_sys);
        `CHK("clamp_4096", 1'b1, dac_clamp)
        @(negedge clk_sys);
        repeat (300) begin
            @(negedge clk_sys);
            if ({dac_clamp, dac_bit_l, dac_bit_r} !== 3'b100) bad++;
        end
        `CHK("muted_out", 0, bad)
        want_l = 16'h0400;
        @(negedge clk_sys);
        `CHK("clamp_hold", 1'b1, dac_clamp)
        hold_on = 1'b0;
        @(negedge clk_sys);
        `CHK("clamp_leave", 1'b0, dac_clamp)
        repeat (2048) begin
            @(negedge clk_sys);
            ones += int'(dac_bit_l === 1'b1);
        end
        `CHK("resume", 1'b1, 1'(ones > 0))
    endtask

    // ****************************************
    // sequence and watchdog
    // ****************************************
    initial begin
        t_reset();
        t_dc(16'sh4000, 16'shC000);
        t_dc(16'shE000, 16'sh2000);
        t_mute();
        t_reset();
        end_sim();
    end

    // whole sequence needs about 39000 cycles
    initial begin
        repeat (60000) @(posedge clk_sys);
        failures++;
        end_sim();
    end
endmodule
